// ==== pkg/mac_pkg.sv ====
// package for the motor converter scan control: register map, channel table, converter structs
package mac_pkg;

  // register byte offsets
  localparam logic [5:0] MAC_OFS_CTRL = 6'h00;
  localparam logic [5:0] MAC_OFS_SMPL = 6'h04;
  localparam logic [5:0] MAC_OFS_STAT = 6'h08;
  localparam logic [5:0] MAC_OFS_RES0 = 6'h10;
  localparam logic [5:0] MAC_OFS_RES_LAST = 6'h34;

  // field positions
  localparam int MAC_CTRL_EN_POS = 0;
  localparam int MAC_STAT_GRP_POS = 0;
  localparam int MAC_STAT_OVR_POS = 4;
  localparam int MAC_STAT_BUSY_POS = 8;

  // reset values
  localparam logic MAC_CTRL_EN_RST = 1'b0;
  localparam logic [7:0] MAC_SMPL_RST = 8'h0F;

  // axi responses
  localparam logic [1:0] MAC_RESP_OKAY = 2'h0;
  localparam logic [1:0] MAC_RESP_SLVERR = 2'h2;

  // virtual channel table, entry 0 at the right
  localparam int MAC_VCH_NUM = 10;
  localparam logic [3:0] MAC_VCH_LAST_IDX = 4'h9;
  localparam logic [9:0][4:0] MAC_VCH_INPUT = {5'h1A, 5'h19, 5'h15, 5'h14, 5'h12,
                                               5'h08, 5'h06, 5'h04, 5'h02, 5'h00};
  localparam logic [9:0][1:0] MAC_VCH_GROUP = {2'h3, 2'h3, 2'h2, 2'h2, 2'h2,
                                               2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
  localparam logic [9:0] MAC_VCH_GRP_END = 10'h294;

  typedef enum logic {MAC_IDLE, MAC_CONV} mac_fsm_e;

  // request to the analog converter core
  typedef struct packed {
    logic start;
    logic [4:0] input_sel;
    logic [7:0] sample_states;
  } mac_conv_req_s;

  // answer from the analog converter core
  typedef struct packed {
    logic done;
    logic [11:0] result;
  } mac_conv_rsp_s;

  // result register window decode
  function automatic logic mac_res_hit(input logic [5:0] a);
    mac_res_hit = (a >= MAC_OFS_RES0) && (a <= MAC_OFS_RES_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] mac_res_idx(input logic [5:0] a);
    logic [5:0] d;
    d = a - MAC_OFS_RES0;
    mac_res_idx = d[5:2];
  endfunction

  function automatic logic mac_addr_ok(input logic [5:0] a);
    mac_addr_ok = (a == MAC_OFS_CTRL) || (a == MAC_OFS_SMPL) || (a == MAC_OFS_STAT) || mac_res_hit(a);
  endfunction

endpackage

// ==== rtl/mac_scan_ctrl.sv ====
// scan control for the twelve_bit_converter: triggered single scan over ten virtual channels
// Behaviour
// - phase currents, bus voltage, speed command sampled in single scan, hardware trigger only.
// - scan starts on the carrier synchronous event, one set per carrier period.
// - ten virtual channels in four groups: 0,2,4 / 6,8 / 18,20,21 / 25,26.
// - every channel uses sampling time entry zero.
// - each channel converted once per scan; no averaging, correction, clipping, filtering.
// - each result delivered as plain 12-bit data.
module mac_scan_ctrl
  import mac_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // axi4-lite write address
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [5:0] i_s_axi_awaddr,
  // axi4-lite write data
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read address
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [5:0] i_s_axi_araddr,
  // axi4-lite read data
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // carrier synchronous trigger from the pwm timer
  input wire logic i_carrier_trig,
  // analog converter core
  output mac_conv_req_s o_conv_req,
  input wire mac_conv_rsp_s i_conv_rsp,
  // results for the readers
  output logic [9:0][11:0] o_result,
  output logic [3:0] o_group_done
);

  typedef struct packed {
    mac_fsm_e fsm;
    logic [3:0] vch;
    logic en;
    logic [7:0] smp;
    logic [3:0] grp;
    logic ovr;
    logic [3:0] grp_pulse;
    logic [9:0][11:0] res;
    mac_conv_req_s conv;
    logic awready;
    logic aw_have;
    logic [5:0] awaddr;
    logic wready;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mac_state_s;

  mac_state_s st;
  mac_state_s next_st;
  logic [3:0] grp_set;
  logic [3:0] grp_clr;
  logic ovr_set;
  logic ovr_clr;
  logic [3:0] vch_inc;

  // read mux; status reflects the state before this cycle's update
  function automatic logic [31:0] mac_read(input mac_state_s s, input logic [5:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == MAC_OFS_CTRL) begin
      d[MAC_CTRL_EN_POS] = s.en;
    end else if (a == MAC_OFS_SMPL) begin
      d[7:0] = s.smp;
    end else if (a == MAC_OFS_STAT) begin
      d[MAC_STAT_GRP_POS +: 4] = s.grp;
      d[MAC_STAT_OVR_POS] = s.ovr;
      d[MAC_STAT_BUSY_POS] = (s.fsm == MAC_CONV);
    end else if (mac_res_hit(a)) begin
      d[11:0] = s.res[mac_res_idx(a)];
    end
    mac_read = d;
  endfunction

  always_comb begin
    next_st = st;
    grp_set = 4'h0;
    grp_clr = 4'h0;
    ovr_set = 1'b0;
    ovr_clr = 1'b0;
    vch_inc = 4'(st.vch + 4'h1);
    next_st.conv.start = 1'b0;

    // write address and data are taken in either order
    if (i_s_axi_awvalid && st.awready) begin
      next_st.awready = 1'b0;
      next_st.aw_have = 1'b1;
      next_st.awaddr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && st.wready) begin
      next_st.wready = 1'b0;
      next_st.w_have = 1'b1;
      next_st.wdata = i_s_axi_wdata;
      next_st.wstrb = i_s_axi_wstrb;
    end
    // all writable fields live in byte lane 0
    if (st.aw_have && st.w_have && !st.bvalid) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = MAC_RESP_OKAY;
      case (st.awaddr)
        MAC_OFS_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.en = st.wdata[MAC_CTRL_EN_POS];
          end
        end
        MAC_OFS_SMPL: begin
          if (st.wstrb[0]) begin
            next_st.smp = st.wdata[7:0];
          end
        end
        MAC_OFS_STAT: begin
          if (st.wstrb[0]) begin
            grp_clr = st.wdata[MAC_STAT_GRP_POS +: 4];
            ovr_clr = st.wdata[MAC_STAT_OVR_POS];
          end
        end
        default: begin
          // result registers are read only; writes to them are dropped
          if (!mac_res_hit(st.awaddr)) begin
            next_st.bresp = MAC_RESP_SLVERR;
          end
        end
      endcase
    end
    // one write under way at a time: readies come back only after the response
    if (st.bvalid && i_s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // read channel
    if (i_s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = mac_read(st, i_s_axi_araddr);
      next_st.rresp = mac_addr_ok(i_s_axi_araddr) ? MAC_RESP_OKAY : MAC_RESP_SLVERR;
    end
    if (st.rvalid && i_s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // scan sequencer
    case (st.fsm)
      MAC_IDLE: begin
        // no software start path: only the carrier event launches a scan
        if (i_carrier_trig && st.en) begin
          next_st.fsm = MAC_CONV;
          next_st.vch = 4'h0;
          next_st.conv.start = 1'b1;
          next_st.conv.input_sel = MAC_VCH_INPUT[0];
          next_st.conv.sample_states = st.smp;
        end
      end
      MAC_CONV: begin
        // a trigger during a scan is dropped, the carrier period was too short
        if (i_carrier_trig) begin
          ovr_set = 1'b1;
        end
        if (i_conv_rsp.done) begin
          next_st.res[st.vch] = i_conv_rsp.result;
          if (MAC_VCH_GRP_END[st.vch]) begin
            grp_set[MAC_VCH_GROUP[st.vch]] = 1'b1;
          end
          if (st.vch == MAC_VCH_LAST_IDX) begin
            next_st.fsm = MAC_IDLE;
          end else begin
            next_st.vch = vch_inc;
            next_st.conv.start = 1'b1;
            next_st.conv.input_sel = MAC_VCH_INPUT[vch_inc];
            next_st.conv.sample_states = st.smp;
          end
        end
      end
      default: begin
        next_st.fsm = MAC_IDLE;
      end
    endcase

    // sticky flags: a set in the clearing cycle wins
    next_st.grp_pulse = grp_set;
    next_st.grp = (st.grp & ~grp_clr) | grp_set;
    next_st.ovr = (st.ovr & ~ovr_clr) | ovr_set;

    if (i_reset) begin
      next_st = '0;
      next_st.fsm = MAC_IDLE;
      next_st.en = MAC_CTRL_EN_RST;
      next_st.smp = MAC_SMPL_RST;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st <= next_st;
  end

  assign o_s_axi_awready = st.awready;
  assign o_s_axi_wready = st.wready;
  assign o_s_axi_bvalid = st.bvalid;
  assign o_s_axi_bresp = st.bresp;
  assign o_s_axi_arready = st.arready;
  assign o_s_axi_rvalid = st.rvalid;
  assign o_s_axi_rdata = st.rdata;
  assign o_s_axi_rresp = st.rresp;
  assign o_conv_req = st.conv;
  assign o_result = st.res;
  assign o_group_done = st.grp_pulse;

  // checking helper: conversions started in the current scan
  logic [3:0] chk_starts;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      chk_starts <= 4'h0;
    end else if (o_conv_req.start && st.vch == 4'h0) begin
      chk_starts <= 4'h1;
    end else if (o_conv_req.start) begin
      chk_starts <= 4'(chk_starts + 4'h1);
    end
  end

  default clocking mac_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  sequence s_trig_taken;
    i_carrier_trig && st.en && (st.fsm == MAC_IDLE);
  endsequence

  sequence s_first_start;
    o_conv_req.start && (o_conv_req.input_sel == 5'h00) && (st.vch == 4'h0);
  endsequence

  sequence s_done_at(logic [3:0] k);
    (st.fsm == MAC_CONV) && i_conv_rsp.done && (st.vch == k);
  endsequence

  a_trig_launches_scan: assert property (s_trig_taken |=> s_first_start)
    else $error("trigger did not launch a scan at input zero");

  a_start_has_trigger: assert property ((o_conv_req.start && $past(st.fsm) == MAC_IDLE)
    |-> ($past(i_carrier_trig) && $past(st.en)))
    else $error("scan started without a carrier trigger");

  a_group_one_map: assert property (s_done_at(4'h2)
    |=> (o_conv_req.start && o_conv_req.input_sel == 5'h06 && o_group_done == 4'h1))
    else $error("group zero end or group one first input wrong");

  a_group_three_map: assert property (s_done_at(4'h7)
    |=> (o_conv_req.input_sel == 5'h19 && o_group_done == 4'h4))
    else $error("group two end or group three first input wrong");

  a_sample_entry: assert property (o_conv_req.start |-> o_conv_req.sample_states == $past(st.smp))
    else $error("conversion not using sampling entry zero");

  a_once_per_scan: assert property (($past(st.fsm) == MAC_CONV && st.fsm == MAC_IDLE)
    |-> (chk_starts == 4'hA && o_group_done == 4'h8))
    else $error("scan did not convert each channel exactly once");

  a_result_stored: assert property ((st.fsm == MAC_CONV && i_conv_rsp.done)
    |=> o_result[$past(st.vch)] == $past(i_conv_rsp.result))
    else $error("result not stored unchanged");

  a_result_held: assert property ((st.fsm == MAC_IDLE && !i_carrier_trig) |=> $stable(o_result))
    else $error("result changed without conversion");

  a_group_done_cause: assert property ((o_group_done != 4'h0) |-> $past(i_conv_rsp.done))
    else $error("group completion without a finished conversion");

  a_bvalid_held: assert property ((o_s_axi_bvalid && !i_s_axi_bready) |=> o_s_axi_bvalid)
    else $error("write response dropped before taken");

endmodule

// ==== tb/mac_conv_model.sv ====
// converter core model: one result per start after a settable delay
module mac_conv_model
  import mac_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // request and answer
  input wire mac_conv_req_s i_conv_req,
  output mac_conv_rsp_s o_conv_rsp,
  // result tag and delay, delay at least 1
  input wire logic [3:0] i_tag,
  input wire logic [3:0] i_delay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic [4:0] sel;
  always_ff @(posedge i_clk_sys) begin
    o_conv_rsp.done <= 1'b0;
    // idle result bus toggles so a stale value never passes
    o_conv_rsp.result <= ~o_conv_rsp.result;
    if (i_reset) begin
      cnt <= 4'h0;
      o_conv_rsp <= '0;
    end else if (i_conv_req.start) begin
      cnt <= i_delay;
      sel <= i_conv_req.input_sel;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        o_conv_rsp.done <= 1'b1;
        o_conv_rsp.result <= {i_tag, 3'h0, sel};
      end
    end
  end
endmodule

// ==== tb/motor_adc_scan_control_test.sv ====
// testbench for the converter scan control
module motor_adc_scan_control_test;
  import mac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] INP [10] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h12, 5'h14, 5'h15, 5'h19, 5'h1A};
  logic clk, rst, awv, wv, bry, arv, rry, trig;
  logic [5:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws, tag, dly, gd;
  logic aw_rdy, w_rdy, bv, ar_rdy, rv;
  logic [1:0] br, rr;
  mac_conv_req_s req;
  mac_conv_rsp_s rsp;
  logic [9:0][11:0] res;
  int bad_count, tests_run, ns, ng;
  logic [4:0] sels [10];
  logic [3:0] gds [4];

  mac_scan_ctrl dut (.i_clk_sys(clk), .i_reset(rst), .i_s_axi_awvalid(awv), .o_s_axi_awready(aw_rdy),
    .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(w_rdy), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(ar_rdy), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rry), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .i_carrier_trig(trig),
    .o_conv_req(req), .i_conv_rsp(rsp), .o_result(res), .o_group_done(gd));
  mac_conv_model model (.i_clk_sys(clk), .i_reset(rst), .i_conv_req(req), .o_conv_rsp(rsp),
    .i_tag(tag), .i_delay(dly));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // log starts and group pulses in the cycle they stand
  always @(posedge clk) begin
    if (req.start === 1'b1) begin
      if (ns < 10) sels[ns] = req.input_sel;
      ns++;
    end
    if (gd !== 4'h0) begin
      if (ng < 4) gds[ng] = gd;
      ng++;
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task tmo;
    bad_count++;
    $display("wrong value wait expected answer seen timeout");
    results();
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy === 1'b1) awv <= 1'b0;
      if (w_rdy === 1'b1) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    chk("bresp", 32'(e), 32'(br));
  endtask

  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_rdy === 1'b1) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    chk(nm, e, rdat);
    chk("rresp", 32'(er), 32'(rr));
  endtask

  // one triggered scan; ov adds a second trigger while busy
  task automatic scan(input logic [3:0] t, input logic [3:0] dl, input logic [7:0] sm, input logic ov);
    int n;
    n = 0;
    wr(MAC_OFS_SMPL, 32'(sm), MAC_RESP_OKAY);
    tag <= t;
    dly <= dl;
    ns = 0;
    ng = 0;
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    if (ov) begin
      repeat (3) @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      rchk("busy", MAC_OFS_STAT, 32'h110, MAC_RESP_OKAY);
    end
    while (ng < 4 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) tmo();
    repeat (3) @(posedge clk);
    chk("starts", 32'd10, 32'(ns));
    for (int k = 0; k < 10; k++) begin
      chk("input", 32'(INP[k]), 32'(sels[k]));
      chk("result", 32'({t, 3'h0, INP[k]}), 32'(res[k]));
    end
    for (int g = 0; g < 4; g++) chk("group", 32'(4'h1 << g), 32'(gds[g]));
    chk("sampling", 32'(sm), 32'(req.sample_states));
    rchk("status", MAC_OFS_STAT, 32'({ov, 4'hF}), MAC_RESP_OKAY);
    wr(MAC_OFS_STAT, 32'h1F, MAC_RESP_OKAY);
    rchk("status", MAC_OFS_STAT, 32'h0, MAC_RESP_OKAY);
    rchk("resreg", MAC_OFS_RES_LAST, 32'({t, 3'h0, 5'h1A}), MAC_RESP_OKAY);
  endtask

  initial begin
    rst = 1'b1;
    {awv, wv, bry, arv, rry, trig} = 6'h00;
    awa = 6'h00;
    ara = 6'h00;
    wd = 32'h0;
    ws = 4'hF;
    tag = 4'h0;
    dly = 4'h1;
    bad_count = 0;
    tests_run = 0;
    ns = 0;
    ng = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("ctrl", MAC_OFS_CTRL, 32'h0, MAC_RESP_OKAY);
    rchk("smpl", MAC_OFS_SMPL, 32'h0F, MAC_RESP_OKAY);
    rchk("unmapped", 6'h3C, 32'h0, MAC_RESP_SLVERR);
    wr(6'h3C, 32'h1, MAC_RESP_SLVERR);
    wr(MAC_OFS_RES0, 32'hFFF, MAC_RESP_OKAY);
    rchk("res0", MAC_OFS_RES0, 32'h0, MAC_RESP_OKAY);
    ws <= 4'hE;
    wr(MAC_OFS_CTRL, 32'h1, MAC_RESP_OKAY);
    rchk("ctrl", MAC_OFS_CTRL, 32'h0, MAC_RESP_OKAY);
    ws <= 4'hF;
    // trigger ignored while disabled
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (20) @(posedge clk);
    chk("starts", 32'h0, 32'(ns));
    wr(MAC_OFS_CTRL, 32'h1, MAC_RESP_OKAY);
    scan(4'h3, 4'h1, 8'h2C, 1'b0);
    scan(4'hA, 4'h7, 8'hB1, 1'b1);
    results();
  end
endmodule
